// *** hdl/ceh_exc_unit.sv ***
// Instruction exception sequencer with APB register access
//
// Implementation choices: the placing of the registers and the APB register port.
`include "ceh_cfg.svh"
module ceh_exc_unit (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic            dec_valid,
   input  wire logic            dec_in_slot,
   input  wire logic            dec_undef,
   input  wire logic            dec_unsigned_divide_instr,
   input  wire logic            dec_signed_divide_instr,
   input  wire logic [31:0]     dec_pc,
   input  wire logic [31:0]     dividend,
   input  wire logic [31:0]     divisor,
   input  wire logic            fp_valid,
   input  wire logic [4:0]      fp_cause,
   input  wire logic            fp_qnan_inf,
   input  wire logic [3:0]      ext_req,
   input  wire logic [31:0]     status_reg,
   output ceh_pkg::ceh_mem_s    mem,
   input  wire logic            mem_ack,
   input  wire logic [31:0]     mem_rdata,
   output logic                 dec_stall,
   output logic                 jump_valid,
   output logic [31:0]          jump_addr,
   output logic                 jump_delayed,
   output logic                 fpu_halt
);
   ceh_pkg::ceh_regs_s r;        // Registered state
   ceh_pkg::ceh_regs_s next_r;   // Next state
   logic [4:0]  fp_eff;          // Cause of this floating op
   logic        fp_take;         // Enabled floating source seen
   logic        accept;          // Decoded non-slot instruction can take an exception while idle
   logic        div_zero;        // Zero divisor on a divide
   logic        div_ovf;         // Signed overflow case
   logic        apb_wr;          // Write completes this edge
   logic        apb_rd;          // Read answered next edge
   logic [31:0] fscr_view;       // Packed floating status word

   // Quiet NaN select widens the invalid cause
   assign fp_eff = fp_cause | {fp_valid & r.quiet_nan_signal_select & r.en[`CEH_V_BIT] & fp_qnan_inf, 4'h0};
   assign fp_take = fp_valid & |(fp_eff & r.en);
   // Only a non-slot decode while idle may take a new exception; a held stacking fault needs none
   assign accept = dec_valid & ~dec_in_slot & (r.state == ceh_pkg::CEH_IDLE);
   assign div_zero = (dec_unsigned_divide_instr | dec_signed_divide_instr) & (divisor == 32'h0000_0000);
   assign div_ovf = dec_signed_divide_instr & (dividend == `CEH_NEG_MAX) & (divisor == `CEH_MINUS_ONE);
   assign apb_wr = psel & penable & pwrite & r.pready;
   assign apb_rd = psel & penable & ~pwrite & ~r.pready;
   assign fscr_view = {16'h0000, r.quiet_nan_signal_select, r.cause, r.en, r.flag};

   // Next state: bus slave, floating status and the stacking sequence
   always_comb
   begin
      next_r = r;
      next_r.jump_valid = 1'b0;
      next_r.jump_delayed = 1'b0;
      // Answer each access phase one cycle late
      next_r.pready = psel & penable & ~r.pready;
      next_r.pslverr = 1'b0;
      if (apb_rd)
      begin
         unique case (paddr)
            `CEH_OFS_VBR:  next_r.prdata = r.vector_base_reg;
            `CEH_OFS_SP:   next_r.prdata = r.sp;
            `CEH_OFS_FSCR: next_r.prdata = fscr_view;
            `CEH_OFS_STAT: next_r.prdata = {16'h0000, r.vec, r.ae_pend, r.in_ae,
                                            r.fpu_pend, r.pend[3:0], 1'b0};
            default:
            begin
               next_r.prdata = 32'h0000_0000;
               next_r.pslverr = 1'b1; // Unmapped address
            end
         endcase
      end
      if (apb_wr)
      begin
         if (paddr == `CEH_OFS_VBR)
            next_r.vector_base_reg = pwdata;
         // Pointer writes while stacking would corrupt the frame
         if (paddr == `CEH_OFS_SP && r.state == ceh_pkg::CEH_IDLE)
            next_r.sp = pwdata;
         if (paddr == `CEH_OFS_FSCR)
         begin
            next_r.flag = pwdata[`CEH_FLAG_LSB +: 5];
            next_r.en = pwdata[`CEH_EN_LSB +: 5];
            next_r.cause = pwdata[`CEH_CAUSE_LSB +: 5];
            next_r.quiet_nan_signal_select = pwdata[`CEH_QIS_BIT];
         end
      end
      // Floating status after software, so detection wins
      if (fp_valid)
      begin
         next_r.cause = fp_eff;
         next_r.flag = next_r.flag | fp_eff;
      end
      // Sources held until an accepting decode, set wins over take
      next_r.pend = r.pend | ext_req;
      if (fp_take)
         next_r.fpu_pend = 1'b1;
      unique case (r.state)
         ceh_pkg::CEH_IDLE:
         begin
            next_r.vec = 8'h00;
            if (r.ae_pend)
            begin
               // Stacking fault handled before anything new
               next_r.vec = `CEH_VEC_ADDRERR;
               next_r.save_pc = r.vec_addr;
               next_r.ae_pend = 1'b0;
               next_r.in_ae = 1'b1;
            end
            else if (accept)
            begin
               next_r.save_pc = dec_pc;
               if (r.pend[0])
               begin
                  next_r.vec = `CEH_VEC_ADDRERR;
                  next_r.pend[0] = ext_req[0];
                  next_r.in_ae = 1'b1;
               end
               else if (r.pend[1])
               begin
                  next_r.vec = `CEH_VEC_BUSERR;
                  next_r.pend[1] = ext_req[1];
               end
               else if (r.pend[2])
               begin
                  next_r.vec = `CEH_VEC_BANKOVF;
                  next_r.pend[2] = ext_req[2];
               end
               else if (r.pend[3])
               begin
                  next_r.vec = `CEH_VEC_IRQ;
                  next_r.pend[3] = ext_req[3];
               end
               else if (r.fpu_pend)
               begin
                  next_r.vec = `CEH_VEC_FPU;
                  next_r.fpu_pend = fp_take;
               end
               else if (dec_undef)
                  next_r.vec = `CEH_VEC_ILLEGAL;
               else if (div_zero)
                  next_r.vec = `CEH_VEC_DIVZ;
               else if (div_ovf)
                  next_r.vec = `CEH_VEC_DIVOVF;
            end
            if (next_r.vec != 8'h00)
            begin
               next_r.state = ceh_pkg::CEH_FETCH;
               next_r.save_sr = status_reg;
               next_r.mem.req = 1'b1;
               next_r.mem.we = 1'b0;
               next_r.mem.addr = r.vector_base_reg + {22'h000000, next_r.vec, 2'b00};
               // A misaligned base faults unless already in that handler
               if (r.vector_base_reg[1:0] != 2'b00 && !next_r.in_ae)
                  next_r.ae_pend = 1'b1;
            end
         end
         ceh_pkg::CEH_FETCH:
            if (mem_ack)
            begin
               next_r.vec_addr = mem_rdata;
               next_r.sp = r.sp - `CEH_WORD_STEP;
               next_r.mem.we = 1'b1;
               next_r.mem.addr = r.sp - `CEH_WORD_STEP;
               next_r.mem.wdata = r.save_sr;
               next_r.state = ceh_pkg::CEH_PUSH_SR;
               if (r.sp[1:0] != 2'b00 && !r.in_ae)
                  next_r.ae_pend = 1'b1;
            end
         ceh_pkg::CEH_PUSH_SR:
            if (mem_ack)
            begin
               // Write still issued at a faulty pointer, data still the saved PC
               next_r.sp = r.sp - `CEH_WORD_STEP;
               next_r.mem.addr = r.sp - `CEH_WORD_STEP;
               next_r.mem.wdata = r.save_pc;
               next_r.state = ceh_pkg::CEH_PUSH_PC;
            end
         ceh_pkg::CEH_PUSH_PC:
            if (mem_ack)
            begin
               next_r.mem.req = 1'b0;
               next_r.mem.we = 1'b0;
               next_r.jump_valid = 1'b1;
               next_r.jump_addr = r.vec_addr;
               next_r.state = ceh_pkg::CEH_JUMP;
            end
         ceh_pkg::CEH_JUMP:
         begin
            next_r.in_ae = 1'b0;
            next_r.state = ceh_pkg::CEH_IDLE;
         end
         default: next_r.state = ceh_pkg::CEH_IDLE;
      endcase
      next_r.dec_stall = (next_r.state != ceh_pkg::CEH_IDLE);
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.state <= ceh_pkg::CEH_IDLE;
         r.vector_base_reg <= `CEH_RST_VBR;
         r.sp <= `CEH_RST_SP;
      end
      else
         r <= next_r;
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign mem = r.mem;
   assign dec_stall = r.dec_stall;
   assign jump_valid = r.jump_valid;
   assign jump_addr = r.jump_addr;
   assign jump_delayed = r.jump_delayed;
   assign fpu_halt = r.fpu_pend;

   // Checks on the sequencer
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic quiet; // No held source would win
   assign quiet = accept & !r.ae_pend & (r.pend == 4'h0) & !r.fpu_pend;

   AST_ILLEGAL: assert property (quiet && dec_undef |=>
      r.vec == `CEH_VEC_ILLEGAL && r.save_pc == $past(dec_pc)) else $error("illegal vector");
   AST_DIVZ: assert property (quiet && !dec_undef && div_zero |=>
      r.vec == `CEH_VEC_DIVZ && r.state == ceh_pkg::CEH_FETCH) else $error("divide by zero");
   AST_UNSIGNED_DIVIDE_INSTR_NO_OVF: assert property (quiet && !dec_undef && dec_unsigned_divide_instr && !dec_signed_divide_instr &&
      divisor != 32'h0000_0000 |=> r.state == ceh_pkg::CEH_IDLE) else $error("unsigned trapped");
   AST_DIVOVF_PC: assert property (quiet && !dec_undef && !div_zero && div_ovf |=>
      r.vec == `CEH_VEC_DIVOVF && r.save_pc == $past(dec_pc)) else $error("overflow frame");
   AST_JUMP: assert property (r.state == ceh_pkg::CEH_PUSH_PC && mem_ack |=>
      jump_valid && !jump_delayed && jump_addr == r.vec_addr ##1 !jump_valid)
      else $error("jump wrong");
   AST_FP_MASK: assert property (fp_valid && (fp_eff & r.en) == 5'h00 && !r.fpu_pend
      |=> !fpu_halt) else $error("masked trap taken");
   AST_FP_HALT: assert property (fp_valid && (fp_eff & r.en) != 5'h00 |=> fpu_halt)
      else $error("no halt");
   AST_FP_FRAME: assert property (accept && !r.ae_pend && r.pend == 4'h0 &&
      r.fpu_pend |=> r.vec == `CEH_VEC_FPU && r.save_pc == $past(dec_pc))
      else $error("fpu frame");
   AST_FLAG: assert property (fp_valid |=> (r.flag & $past(fp_eff)) == $past(fp_eff))
      else $error("flag lost");
   AST_CAUSE: assert property (fp_valid |=> r.cause == $past(fp_eff))
      else $error("cause stale");
   AST_QIS: assert property (fp_valid && r.quiet_nan_signal_select && r.en[`CEH_V_BIT] && fp_qnan_inf |=>
      fpu_halt && r.cause[`CEH_V_BIT]) else $error("qnan missed");
   AST_SLOT_HOLD: assert property (r.state == ceh_pkg::CEH_IDLE && dec_valid &&
      dec_in_slot && !r.ae_pend |=> r.state == ceh_pkg::CEH_IDLE) else $error("slot taken");
   AST_STACK: assert property (r.state == ceh_pkg::CEH_PUSH_SR && mem_ack |=>
      mem.we && mem.addr == r.sp && mem.wdata == r.save_pc) else $error("stack order");
   AST_AE_SET: assert property (r.state == ceh_pkg::CEH_FETCH && mem_ack &&
      r.sp[1:0] != 2'b00 && !r.in_ae |=> r.ae_pend) else $error("no address error");
   AST_AE_TAKE: assert property (r.state == ceh_pkg::CEH_JUMP && r.ae_pend |=>
      ##1 r.state == ceh_pkg::CEH_FETCH && r.vec == `CEH_VEC_ADDRERR) else $error("ae late");
   AST_AE_IGNORE: assert property (r.in_ae && r.state != ceh_pkg::CEH_IDLE && !r.ae_pend
      |=> !r.ae_pend) else $error("ae loop");
   AST_SP_STEP: assert property (r.state == ceh_pkg::CEH_FETCH && mem_ack |=>
      r.sp == $past(r.sp) - `CEH_WORD_STEP && mem.req) else $error("sp step");

   // Status word goes out first, one word below the pointer
   AST_STACK_SR: assert property (r.state == ceh_pkg::CEH_FETCH && mem_ack |=>
      mem.we && mem.addr == r.sp && mem.wdata == r.save_sr) else $error("status push");
   // A misaligned base alone must raise the fault too
   AST_VBR_AE: assert property (quiet && dec_undef && r.vector_base_reg[1:0] != 2'b00 |=>
      r.ae_pend) else $error("base fault missed");
   // Follow-up frame saves the faulting vector and blocks new faults
   AST_AE_SAVE: assert property (r.state == ceh_pkg::CEH_IDLE && r.ae_pend |=>
      r.vec == `CEH_VEC_ADDRERR && r.save_pc == $past(r.vec_addr) && r.in_ae)
      else $error("ae frame");
   // Sticky flags change only by detection or by software
   AST_FLAG_HOLD: assert property (!fp_valid && !(apb_wr && paddr == `CEH_OFS_FSCR) |=>
      r.flag == $past(r.flag)) else $error("flag changed");
   // Partner may stall: the request must not move meanwhile
   AST_MEM_HOLD: assert property (mem.req && !mem_ack |=> $stable(mem))
      else $error("request moved");
   // Register bus answer is one cycle, error only alongside it
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready stuck");
   AST_SLVERR_QUAL: assert property (pslverr |-> pready)
      else $error("stray slave error");
   // Halt drops once the held floating trap is taken
   AST_HALT_DROP: assert property (accept && !r.ae_pend && r.pend == 4'h0 && r.fpu_pend &&
      !fp_take |=> !fpu_halt) else $error("halt kept");

   COV_DIV: cover property (r.state == ceh_pkg::CEH_FETCH && r.vec == `CEH_VEC_DIVZ);
   COV_FPU: cover property (jump_valid && r.vec == `CEH_VEC_FPU);
   COV_AE_CHAIN: cover property (r.in_ae && r.state == ceh_pkg::CEH_PUSH_PC);
   COV_SLOT: cover property (dec_valid && dec_in_slot && ext_req != 4'h0);
   // Address error frame fetched while the base is misaligned
   COV_BASE_AE: cover property (r.state == ceh_pkg::CEH_FETCH && r.in_ae && r.vector_base_reg[1:0] != 2'b00);
endmodule

// *** include/ceh_cfg.svh ***
// Offsets, field positions, reset values and vector numbers of the exception unit
`ifndef CEH_CFG_SVH
`define CEH_CFG_SVH
`define CEH_OFS_VBR     12'h000
`define CEH_OFS_SP      12'h004
`define CEH_OFS_FSCR    12'h008
`define CEH_OFS_STAT    12'h00c
`define CEH_FLAG_LSB    0
`define CEH_EN_LSB      5
`define CEH_CAUSE_LSB   10
`define CEH_QIS_BIT     15
`define CEH_V_BIT       4
`define CEH_RST_VBR     32'h0000_0000
`define CEH_RST_SP      32'h0000_0000
`define CEH_RST_FSCR    32'h0000_0000
`define CEH_VEC_ILLEGAL 8'h04
`define CEH_VEC_ADDRERR 8'h09
`define CEH_VEC_BUSERR  8'h0b
`define CEH_VEC_BANKOVF 8'h0c
`define CEH_VEC_DIVZ    8'h0d
`define CEH_VEC_DIVOVF  8'h0e
`define CEH_VEC_FPU     8'h0f
`define CEH_VEC_IRQ     8'h40
`define CEH_WORD_STEP   32'h0000_0004
`define CEH_NEG_MAX     32'h8000_0000
`define CEH_MINUS_ONE   32'hffff_ffff
`endif

// *** include/ceh_pkg.sv ***
// Types shared by the exception unit
package ceh_pkg;
   // Sequence states, Gray coded along the usual path from CEH_IDLE to CEH_JUMP
   typedef enum logic [2:0] {
      CEH_IDLE    = 3'b000,
      CEH_FETCH   = 3'b001,
      CEH_PUSH_SR = 3'b011,
      CEH_PUSH_PC = 3'b010,
      CEH_JUMP    = 3'b110
   } ceh_state_e;

   // Bus request towards vector reads and stack writes
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ceh_mem_s;

   // Whole state of the unit
   typedef struct packed {
      ceh_state_e  state;
      ceh_mem_s    mem;
      logic [31:0] vector_base_reg;
      logic [31:0] sp;
      logic [4:0]  flag;
      logic [4:0]  en;
      logic [4:0]  cause;
      logic        quiet_nan_signal_select;
      logic [3:0]  pend;
      logic        fpu_pend;
      logic        ae_pend;
      logic        in_ae;
      logic [7:0]  vec;
      logic [31:0] save_pc;
      logic [31:0] save_sr;
      logic [31:0] vec_addr;
      logic        dec_stall;
      logic        jump_valid;
      logic [31:0] jump_addr;
      logic        jump_delayed;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ceh_regs_s;
endpackage

// *** tb/ceh_bus_model.sv ***
// Bus partner: answers vector reads and logs the last two stack writes
module ceh_bus_model (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire ceh_pkg::ceh_mem_s mem,
   input  wire logic              slow,
   output logic                   mem_ack,
   output logic [31:0]            mem_rdata,
   output logic [31:0]            rd_addr,
   output logic [31:0]            wa0,
   output logic [31:0]            wd0,
   output logic [31:0]            wa1,
   output logic [31:0]            wd1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] dly; // Wait cycles spent on the open request
   // Answers after zero or three waits; read data churns outside answers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {mem_ack, dly, rd_addr, wa0, wd0, wa1, wd1} <= '0;
         mem_rdata <= 32'h0;
      end
      else
      begin
         mem_rdata <= ~mem_rdata; // Stale data must never look valid
         if (mem_ack)
         begin
            mem_ack <= 1'b0;
            dly <= 3'h0;
         end
         else if (mem.req && dly >= {1'b0, slow, slow})
         begin
            mem_ack <= 1'b1;
            if (mem.we)
            begin
               {wa0, wd0} <= {wa1, wd1}; // Older write moves down
               {wa1, wd1} <= {mem.addr, mem.wdata};
            end
            else
            begin
               rd_addr <= mem.addr;
               mem_rdata <= mem.addr ^ 32'h5a00_0000; // Vector content
            end
         end
         else if (mem.req)
            dly <= dly + 3'h1;
      end
   end
endmodule

// *** tb/ceh_exc_unit_tb_top.sv ***
// Self-checking bench for the instruction exception sequencer
`include "ceh_cfg.svh"
module ceh_exc_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SRV = 32'h0000_00f0; // Status value to be stacked
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic              dec_valid, dec_in_slot, dec_undef, dec_unsigned_divide_instr, dec_signed_divide_instr;
   logic              fp_valid, fp_qnan_inf, mem_ack, dec_stall, jump_valid;
   logic              jump_delayed, fpu_halt, slow, e;
   logic [11:0]       paddr;
   logic [4:0]        fp_cause;
   logic [3:0]        ext_req;
   logic [31:0]       pwdata, prdata, dec_pc, dividend, divisor, status_reg;
   logic [31:0]       mem_rdata, jump_addr, rd_addr, wa0, wd0, wa1, wd1, q, spv, vbv;
   ceh_pkg::ceh_mem_s mem;
   int                errors, n_compared;
   // Divide cases: kind {unsigned_divide_instr,signed_divide_instr}, operands, expected vector (0 = none)
   logic [1:0]        dk [5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b01};
   logic [31:0]       dd [5] = '{32'h7, 32'h7, `CEH_NEG_MAX, `CEH_NEG_MAX, 32'h5};
   logic [31:0]       dv [5] = '{32'h0, 32'h0, `CEH_MINUS_ONE, `CEH_MINUS_ONE,
                                 `CEH_MINUS_ONE};
   logic [7:0]        dx [5] = '{`CEH_VEC_DIVZ, `CEH_VEC_DIVZ, `CEH_VEC_DIVOVF, 8'h0, 8'h0};

   ceh_exc_unit ceh_exc_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec_valid(dec_valid),
      .dec_in_slot(dec_in_slot), .dec_undef(dec_undef), .dec_unsigned_divide_instr(dec_unsigned_divide_instr),
      .dec_signed_divide_instr(dec_signed_divide_instr), .dec_pc(dec_pc), .dividend(dividend), .divisor(divisor),
      .fp_valid(fp_valid), .fp_cause(fp_cause), .fp_qnan_inf(fp_qnan_inf),
      .ext_req(ext_req), .status_reg(status_reg), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .dec_stall(dec_stall), .jump_valid(jump_valid),
      .jump_addr(jump_addr), .jump_delayed(jump_delayed), .fpu_halt(fpu_halt));
   ceh_bus_model ceh_bus_model_inst (.pclk(pclk), .presetn(presetn), .mem(mem),
      .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rd_addr(rd_addr),
      .wa0(wa0), .wd0(wd0), .wa1(wa1), .wd1(wd1));

   // Free-running 4 ns clock
   always #2 pclk = ~pclk;

   // Verdict and end of run
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Value comparison, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
      begin
         errors++;
         report_and_stop();
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   // Decode one instruction: k = {slot, undef, unsigned_divide_instr, signed_divide_instr}
   task automatic decode(input logic [3:0] k, input logic [31:0] pc, input logic [31:0] dvs);
      @(posedge pclk);
      {dec_valid, dec_in_slot, dec_undef, dec_unsigned_divide_instr, dec_signed_divide_instr} <= {1'b1, k};
      dec_pc <= pc;
      dividend <= (k[1:0] == 2'b00) ? 32'h0 : dividend;
      divisor <= dvs;
      @(posedge pclk);
      dec_valid <= 1'b0;
   endtask

   // One floating operation result pulse
   task automatic fp_op(input logic [4:0] c, input logic qn);
      @(posedge pclk);
      {fp_valid, fp_cause, fp_qnan_inf} <= {1'b1, c, qn};
      @(posedge pclk);
      {fp_valid, fp_qnan_inf} <= 2'b00;
      @(negedge pclk);
   endtask

   // Nothing may start: the unit stays free
   task automatic idle_chk;
      repeat (6) @(negedge pclk);
      chk({31'h0, dec_stall}, 32'h0);
   endtask

   function automatic logic [31:0] vaddr(input logic [7:0] v);
      return vbv + {22'h0, v, 2'b00};
   endfunction

   // Await the jump and check vector read, stacked words and target
   task automatic seq(input logic [7:0] vec, input logic [31:0] pcv);
      int i;
      for (i = 0; i < 80 && jump_valid !== 1'b1; i++)
         @(negedge pclk);
      if (i == 80)
      begin
         errors++;
         report_and_stop();
      end
      chk(rd_addr, vaddr(vec));
      chk(wa0, spv - 32'h4);
      chk(wd0, SRV);
      chk(wa1, spv - 32'h8);
      chk(wd1, pcv);
      chk(jump_addr, vaddr(vec) ^ 32'h5a00_0000);
      chk({31'h0, jump_delayed}, 32'h0);
      spv = spv - 32'h8;
      @(negedge pclk);
   endtask

   // Main sequence
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
      {dec_valid, dec_in_slot, dec_undef, dec_unsigned_divide_instr, dec_signed_divide_instr, fp_valid} = '0;
      {fp_cause, fp_qnan_inf, ext_req, dec_pc, dividend, divisor} = '0;
      status_reg = SRV;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`CEH_OFS_VBR, `CEH_RST_VBR);
      rd_chk(`CEH_OFS_SP, `CEH_RST_SP);
      rd_chk(`CEH_OFS_FSCR, `CEH_RST_FSCR);
      rd_chk(12'h010, 32'h0);
      chk({31'h0, e}, 32'h1);
      vbv = 32'h100;
      spv = 32'h2000;
      apb(1'b1, `CEH_OFS_VBR, vbv);
      apb(1'b1, `CEH_OFS_SP, spv);
      rd_chk(`CEH_OFS_VBR, vbv);
      $display("test registers done");
      decode(4'b0100, 32'h40, 32'h1);
      seq(`CEH_VEC_ILLEGAL, 32'h40);
      rd_chk(`CEH_OFS_SP, spv);
      $display("test illegal done");
      slow <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge pclk);
         dividend <= dd[i];
         decode({2'b00, dk[i]}, 32'h200 + 32'(4 * i), dv[i]);
         if (dx[i] != 8'h0)
            seq(dx[i], 32'h200 + 32'(4 * i));
         else
            idle_chk();
      end
      $display("test divide done");
      @(posedge pclk);
      ext_req <= 4'b0010;
      @(posedge pclk);
      ext_req <= 4'b0000;
      idle_chk();
      rd_chk(`CEH_OFS_STAT, 32'h4);
      decode(4'b1100, 32'h70, 32'h1);
      idle_chk();
      decode(4'b0000, 32'h80, 32'h1);
      seq(`CEH_VEC_BUSERR, 32'h80);
      $display("test pending done");
      @(posedge pclk);
      slow <= 1'b0;
      fp_op(5'b01000, 1'b0);
      chk({31'h0, fpu_halt}, 32'h0);
      rd_chk(`CEH_OFS_FSCR, 32'h2008);
      fp_op(5'b00001, 1'b0);
      rd_chk(`CEH_OFS_FSCR, 32'h0409);
      apb(1'b1, `CEH_OFS_FSCR, 32'h100);
      fp_op(5'b01000, 1'b0);
      chk({31'h0, fpu_halt}, 32'h1);
      rd_chk(`CEH_OFS_FSCR, 32'h2108);
      decode(4'b0000, 32'h90, 32'h1);
      seq(`CEH_VEC_FPU, 32'h90);
      chk({31'h0, fpu_halt}, 32'h0);
      apb(1'b1, `CEH_OFS_FSCR, 32'h8200);
      fp_op(5'b00000, 1'b1);
      chk({31'h0, fpu_halt}, 32'h1);
      decode(4'b0000, 32'ha0, 32'h1);
      seq(`CEH_VEC_FPU, 32'ha0);
      $display("test float done");
      spv = 32'h2002;
      apb(1'b1, `CEH_OFS_SP, spv);
      decode(4'b0100, 32'h60, 32'h1);
      seq(`CEH_VEC_ILLEGAL, 32'h60);
      seq(`CEH_VEC_ADDRERR, vaddr(`CEH_VEC_ILLEGAL) ^ 32'h5a00_0000);
      idle_chk();
      rd_chk(`CEH_OFS_SP, spv);
      spv = 32'h2000;
      apb(1'b1, `CEH_OFS_SP, spv);
      vbv = 32'h102;
      apb(1'b1, `CEH_OFS_VBR, vbv);
      decode(4'b0100, 32'h64, 32'h1);
      seq(`CEH_VEC_ILLEGAL, 32'h64);
      seq(`CEH_VEC_ADDRERR, vaddr(`CEH_VEC_ILLEGAL) ^ 32'h5a00_0000);
      idle_chk();
      $display("test address error done");
      report_and_stop();
   end
endmodule
